// ---- hw/liu_irq_pkg.sv ----
package liu_irq_pkg;

    // ------------------------------------------------------------
    // Global register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CHIP_REVISION = 8'h00;
    localparam logic [7:0] OFF_SOFT_RESET_TRIGGER = 8'h20;
    localparam logic [7:0] OFF_GLOBAL_CONFIG_A = 8'h40;
    localparam logic [7:0] OFF_GLOBAL_CONFIG_B = 8'h60;
    localparam logic [7:0] OFF_CHANNEL_IRQ_SUMMARY = 8'h80;
    localparam logic [7:0] OFF_RESERVED_A = 8'hA0;
    localparam logic [7:0] OFF_RESERVED_B = 8'hC0;
    localparam logic [7:0] OFF_RESERVED_C = 8'hE0;

    // ------------------------------------------------------------
    // Per-channel register offsets (within one channel's window)
    // ------------------------------------------------------------
    localparam logic [5:0] OFF_EVENT_ENABLE_A = 6'h11;
    localparam logic [5:0] OFF_EVENT_ENABLE_B = 6'h12;
    localparam logic [5:0] OFF_EDGE_SELECT = 6'h13;
    localparam logic [5:0] OFF_LINE_CONDITION_A = 6'h14;
    localparam logic [5:0] OFF_LINE_CONDITION_B = 6'h15;
    localparam logic [5:0] OFF_EVENT_LATCH_A = 6'h16;
    localparam logic [5:0] OFF_EVENT_LATCH_B = 6'h17;
    localparam int CHAN_SEL_LSB = 6;
    localparam int GLOBAL_SEL_BITS = 5;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int GCA_IRQ_PIN_LSB = 0;
    localparam int GCA_IRQ_PIN_MSB = 1;
    localparam int GCA_GLOBAL_IRQ_MASK = 2;
    localparam int GCA_BROADCAST = 3;
    localparam int GCA_LINE_STANDARD_SELECT = 4;
    localparam int GCA_WIDTH = 5;
    localparam int GCB_MONITOR_LSB = 4;
    localparam int GCB_MONITOR_WIDTH = 4;
    localparam int LCB_REMOTE_LOOP = 5;
    localparam int LIVE_EVENTS = 7;
    localparam int PULSE_EVENTS = 8;

    // Interrupt pin drive modes
    localparam logic [1:0] IRQ_PP_LOW = 2'h1;
    localparam logic [1:0] IRQ_PP_HIGH = 2'h2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [GCA_WIDTH-1:0] GCA_RESET = 5'h04;
    localparam logic [GCB_MONITOR_WIDTH-1:0] GCB_RESET = 4'h0;
    localparam logic [7:0] EVENT_ENABLE_RESET = 8'hFF;
    localparam logic [7:0] EDGE_SELECT_RESET = 8'h00;
    // Arbitrary revision value
    localparam logic [7:0] CHIP_REVISION_DEFAULT = 8'h5A;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 40;
    localparam int SOFT_RESET_TIME_NS = 1000;
    localparam int HW_RESET_MIN_NS = 100;
    localparam int SOFT_RESET_CYCLES = (SOFT_RESET_TIME_NS * CLK_FREQ_MHZ) / 1000;
    localparam int HW_RESET_MIN_CYCLES = (HW_RESET_MIN_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int RST_CNT_W = $clog2(SOFT_RESET_CYCLES + 1);
    localparam logic [RST_CNT_W-1:0] RST_CNT_LOAD = RST_CNT_W'(SOFT_RESET_CYCLES - 1);

endpackage

// ---- hw/liu_event_channel.sv ----
`timescale 1ns/1ps
`default_nettype none

module liu_event_channel
    import liu_irq_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_clear,
    input wire logic [LIVE_EVENTS-1:0] i_line_state,
    input wire logic i_remote_loop_state,
    input wire logic [PULSE_EVENTS-1:0] i_event_pulse,
    input wire logic i_wr_enable_a,
    input wire logic i_wr_enable_b,
    input wire logic i_wr_edge_select,
    input wire logic [7:0] i_wr_data,
    input wire logic i_rd_latch_a,
    input wire logic i_rd_latch_b,
    output logic [7:0] o_event_enable_a,
    output logic [7:0] o_event_enable_b,
    output logic [7:0] o_edge_select,
    output logic [7:0] o_line_condition_a,
    output logic [7:0] o_line_condition_b,
    output logic [7:0] o_event_latch_a,
    output logic [7:0] o_event_latch_b,
    output logic o_channel_pending_flag
);

    typedef struct packed {
        logic [7:0] enable_a;
        logic [7:0] enable_b;
        logic [7:0] edge_sel;
        logic [LIVE_EVENTS-1:0] live;
        logic remote;
        logic [LIVE_EVENTS-1:0] latch_a;
        logic [PULSE_EVENTS-1:0] latch_b;
        logic flag;
    } chan_s;

    chan_s state_reg;
    chan_s state_next;
    logic [LIVE_EVENTS-1:0] rise;
    logic [LIVE_EVENTS-1:0] either;
    logic [LIVE_EVENTS-1:0] set_a;
    logic [PULSE_EVENTS-1:0] set_b;

    // ------------------------------------------------------------
    // Event capture
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        rise = i_line_state & ~state_reg.live;
        either = i_line_state ^ state_reg.live;
        set_a = (either & state_reg.edge_sel[LIVE_EVENTS-1:0])
            | (rise & ~state_reg.edge_sel[LIVE_EVENTS-1:0]);
        set_b = i_event_pulse;
        state_next.live = i_line_state;
        state_next.remote = i_remote_loop_state;
        // Set wins over read-clear
        state_next.latch_a = (state_reg.latch_a & ~{LIVE_EVENTS{i_rd_latch_a}}) | set_a;
        state_next.latch_b = (state_reg.latch_b & ~{PULSE_EVENTS{i_rd_latch_b}}) | set_b;
        state_next.flag = (state_reg.flag & ~(i_rd_latch_a | i_rd_latch_b))
            | (|(set_a & ~state_reg.enable_a[LIVE_EVENTS-1:0]))
            | (|(set_b & ~state_reg.enable_b));
        if (i_wr_enable_a) begin
            state_next.enable_a = i_wr_data;
        end
        if (i_wr_enable_b) begin
            state_next.enable_b = i_wr_data;
        end
        if (i_wr_edge_select) begin
            state_next.edge_sel = i_wr_data;
        end
        if (i_clear) begin
            state_next = '0;
            state_next.enable_a = EVENT_ENABLE_RESET;
            state_next.enable_b = EVENT_ENABLE_RESET;
            state_next.edge_sel = EDGE_SELECT_RESET;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= '0;
            state_reg.enable_a <= EVENT_ENABLE_RESET;
            state_reg.enable_b <= EVENT_ENABLE_RESET;
            state_reg.edge_sel <= EDGE_SELECT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_event_enable_a = state_reg.enable_a;
    assign o_event_enable_b = state_reg.enable_b;
    assign o_edge_select = state_reg.edge_sel;
    assign o_line_condition_a = {1'b0, state_reg.live};
    assign o_line_condition_b = 8'(state_reg.remote) << LCB_REMOTE_LOOP;
    assign o_event_latch_a = {1'b0, state_reg.latch_a};
    assign o_event_latch_b = state_reg.latch_b;
    assign o_channel_pending_flag = state_reg.flag;

endmodule

`default_nettype wire

// ---- hw/liu_irq_global_ctrl.sv ----
// Overview of operation
// - Config 00: interrupt pin is open-drain, active low.
// - Config 01: interrupt pin push-pull, low means pending.
// - Config 10: interrupt pin push-pull, high means pending.
// - Global mask bit blocks all interrupt signalling; zero lets it through.
// - Read-only summary register flags channels one to four at bits 0,2,4,6.
// - Each event latched in its own bit, each gated by its own mask bit.
// - Edge select bit picks which live-status transition sets the latch.
// - Reading a channel's event latch clears its summary flag.
// - Interrupt goes inactive once every channel has been acknowledged or the global mask bit is set.
// - Fifteen event kinds; seven have live, latch, edge and mask bits.
// - Eight pulse events have latch and mask only.
// - Any write to soft reset register resets the chip within 1 us.
// - Hardware reset held low at least 100 ns resets the chip.
// - After reset drivers are high impedance and registers take defaults.
// - Global writes affect all channels; local writes only their channel.
// - Broadcast bit set: local writes go to every channel.
// - Global map: revision 00, reset 20, config 40/60, summary 80, reserved.
// - Reading an event latch register clears its latched bits.
`timescale 1ns/1ps
`default_nettype none

module liu_irq_global_ctrl
    import liu_irq_pkg::*;
#(
    parameter int NCH = 4,
    parameter logic [7:0] CHIP_REVISION = CHIP_REVISION_DEFAULT
)
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [NCH-1:0][LIVE_EVENTS-1:0] i_line_state,
    input wire logic [NCH-1:0] i_remote_loop_state,
    input wire logic [NCH-1:0][PULSE_EVENTS-1:0] i_event_pulse,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_irq_out,
    output logic o_irq_oe,
    output logic o_chip_reset,
    output logic o_driver_hiz,
    output logic o_line_standard_select,
    output logic [GCB_MONITOR_WIDTH-1:0] o_monitor_select
);

    typedef struct packed {
        logic [7:0] rd_data;
        logic rd_valid;
        logic [GCA_WIDTH-1:0] cfg_a;
        logic [GCB_MONITOR_WIDTH-1:0] cfg_b;
        logic [RST_CNT_W-1:0] rst_cnt;
        logic chip_reset;
        logic irq_out;
        logic irq_oe;
    } glob_s;

    glob_s state_reg;
    glob_s state_next;

    logic is_global;
    logic [1:0] chan_sel;
    logic [5:0] local_off;
    logic [NCH-1:0] wr_hit;
    logic [NCH-1:0] rd_a_hit;
    logic [NCH-1:0] rd_b_hit;
    logic [NCH-1:0] pending;
    logic [NCH-1:0][7:0] en_a;
    logic [NCH-1:0][7:0] en_b;
    logic [NCH-1:0][7:0] edge_sel;
    logic [NCH-1:0][7:0] cond_a;
    logic [NCH-1:0][7:0] cond_b;
    logic [NCH-1:0][7:0] latch_a;
    logic [NCH-1:0][7:0] latch_b;
    logic [7:0] summary;
    logic irq_active;
    logic [7:0] local_rd;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign is_global = (i_addr[GLOBAL_SEL_BITS-1:0] == '0);
    assign chan_sel = i_addr[7:CHAN_SEL_LSB];
    assign local_off = i_addr[5:0];

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < NCH; c = c + 1) begin : g_chan
            assign wr_hit[c] = i_wr_en & ~is_global & ~state_reg.chip_reset
                & (state_reg.cfg_a[GCA_BROADCAST] | (chan_sel == 2'(c)));
            assign rd_a_hit[c] = i_rd_en & ~is_global & ~state_reg.chip_reset
                & (chan_sel == 2'(c)) & (local_off == OFF_EVENT_LATCH_A);
            assign rd_b_hit[c] = i_rd_en & ~is_global & ~state_reg.chip_reset
                & (chan_sel == 2'(c)) & (local_off == OFF_EVENT_LATCH_B);
            // Summary flag for channel c sits at bit 2c
            assign summary[2*c] = pending[c];
            assign summary[2*c+1] = 1'b0;

            liu_event_channel u_chan (
                .i_sys_clk(i_sys_clk),
                .i_reset_n(i_reset_n),
                .i_clear(state_reg.chip_reset),
                .i_line_state(i_line_state[c]),
                .i_remote_loop_state(i_remote_loop_state[c]),
                .i_event_pulse(i_event_pulse[c]),
                .i_wr_enable_a(wr_hit[c] & (local_off == OFF_EVENT_ENABLE_A)),
                .i_wr_enable_b(wr_hit[c] & (local_off == OFF_EVENT_ENABLE_B)),
                .i_wr_edge_select(wr_hit[c] & (local_off == OFF_EDGE_SELECT)),
                .i_wr_data(i_wr_data),
                .i_rd_latch_a(rd_a_hit[c]),
                .i_rd_latch_b(rd_b_hit[c]),
                .o_event_enable_a(en_a[c]),
                .o_event_enable_b(en_b[c]),
                .o_edge_select(edge_sel[c]),
                .o_line_condition_a(cond_a[c]),
                .o_line_condition_b(cond_b[c]),
                .o_event_latch_a(latch_a[c]),
                .o_event_latch_b(latch_b[c]),
                .o_channel_pending_flag(pending[c])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Local read mux
    // ------------------------------------------------------------
    always_comb begin
        local_rd = 8'h00;
        if (int'(chan_sel) < NCH) begin
            case (local_off)
                OFF_EVENT_ENABLE_A: local_rd = en_a[chan_sel];
                OFF_EVENT_ENABLE_B: local_rd = en_b[chan_sel];
                OFF_EDGE_SELECT: local_rd = edge_sel[chan_sel];
                OFF_LINE_CONDITION_A: local_rd = cond_a[chan_sel];
                OFF_LINE_CONDITION_B: local_rd = cond_b[chan_sel];
                OFF_EVENT_LATCH_A: local_rd = latch_a[chan_sel];
                OFF_EVENT_LATCH_B: local_rd = latch_b[chan_sel];
                default: local_rd = 8'h00;
            endcase
        end
    end

    // Interrupt goes inactive once no channel flag remains or the global mask bit is set
    assign irq_active = (|summary) & ~state_reg.cfg_a[GCA_GLOBAL_IRQ_MASK];

    // ------------------------------------------------------------
    // Global registers, reset sequencing, interrupt pin
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.rd_valid = 1'b0;
        state_next.rd_data = 8'h00;
        if (state_reg.rst_cnt != '0) begin
            state_next.rst_cnt = state_reg.rst_cnt - 1'b1;
        end
        state_next.chip_reset = (state_reg.rst_cnt != '0);
        if (i_rd_en && !state_reg.chip_reset) begin
            state_next.rd_valid = 1'b1;
            if (is_global) begin
                case (i_addr)
                    OFF_CHIP_REVISION: state_next.rd_data = CHIP_REVISION;
                    OFF_GLOBAL_CONFIG_A: state_next.rd_data = 8'(state_reg.cfg_a);
                    OFF_GLOBAL_CONFIG_B:
                        state_next.rd_data = 8'(state_reg.cfg_b) << GCB_MONITOR_LSB;
                    OFF_CHANNEL_IRQ_SUMMARY: state_next.rd_data = summary;
                    default: state_next.rd_data = 8'h00;
                endcase
            end else begin
                state_next.rd_data = local_rd;
            end
        end
        if (i_wr_en && is_global && !state_reg.chip_reset) begin
            case (i_addr)
                OFF_SOFT_RESET_TRIGGER: state_next.rst_cnt = RST_CNT_LOAD;
                OFF_GLOBAL_CONFIG_A: state_next.cfg_a = i_wr_data[GCA_WIDTH-1:0];
                OFF_GLOBAL_CONFIG_B:
                    state_next.cfg_b = i_wr_data[GCB_MONITOR_LSB +: GCB_MONITOR_WIDTH];
                default: state_next.cfg_a = state_reg.cfg_a;
            endcase
        end
        // Interrupt pin drive
        // Mode 10 checked first so push-pull high is reachable
        if (state_reg.cfg_a[GCA_IRQ_PIN_MSB:GCA_IRQ_PIN_LSB] == IRQ_PP_HIGH) begin
            state_next.irq_out = irq_active;
            state_next.irq_oe = 1'b1;
        end else if (!state_reg.cfg_a[GCA_IRQ_PIN_LSB]) begin
            state_next.irq_out = 1'b0;
            state_next.irq_oe = irq_active;
        end else begin
            state_next.irq_out = ~irq_active;
            state_next.irq_oe = 1'b1;
        end
        if (state_reg.chip_reset) begin
            state_next.cfg_a = GCA_RESET;
            state_next.cfg_b = GCB_RESET;
            state_next.irq_out = 1'b0;
            state_next.irq_oe = 1'b0;
        end
    end

    // Async reset covers the hardware pin; release is followed by a
    // full sequenced chip reset of the same length as a soft reset
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg.rd_data <= 8'h00;
            state_reg.rd_valid <= 1'b0;
            state_reg.cfg_a <= GCA_RESET;
            state_reg.cfg_b <= GCB_RESET;
            state_reg.rst_cnt <= RST_CNT_LOAD;
            state_reg.chip_reset <= 1'b1;
            state_reg.irq_out <= 1'b0;
            state_reg.irq_oe <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_rd_data = state_reg.rd_data;
    assign o_rd_valid = state_reg.rd_valid;
    assign o_irq_out = state_reg.irq_out;
    assign o_irq_oe = state_reg.irq_oe;
    assign o_chip_reset = state_reg.chip_reset;
    assign o_driver_hiz = state_reg.chip_reset;
    assign o_line_standard_select = state_reg.cfg_a[GCA_LINE_STANDARD_SELECT];
    assign o_monitor_select = state_reg.cfg_b;

endmodule

`default_nettype wire

// ---- tb/liu_irq_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module liu_irq_checker
    import liu_irq_pkg::*;
#(
    parameter logic [7:0] CHIP_REVISION = CHIP_REVISION_DEFAULT
)
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_addr,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] o_rd_data,
    input wire logic o_rd_valid,
    input wire logic o_irq_oe,
    input wire logic o_chip_reset,
    input wire logic o_driver_hiz
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);
    wire logic rd_ok = i_rd_en && !o_chip_reset;
    property p_rd_answer;
        rd_ok |=> o_rd_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_no_answer;
        !rd_ok |=> !o_rd_valid;
    endproperty
    a_no_answer: assert property (p_no_answer) else $error("read answered unasked");
    property p_reserved;
        rd_ok && i_addr inside {8'h20, 8'hA0, 8'hC0, 8'hE0} |=> o_rd_data == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved read not zero");
    property p_revision;
        rd_ok && i_addr == 8'h00 |=> o_rd_valid && o_rd_data == CHIP_REVISION;
    endproperty
    a_revision: assert property (p_revision) else $error("revision read wrong");
    property p_summary_odd;
        rd_ok && i_addr == 8'h80 |=> (o_rd_data & 8'hAA) == 8'h00;
    endproperty
    a_summary_odd: assert property (p_summary_odd) else $error("summary odd bit set");
    property p_soft_start;
        i_wr_en && !o_chip_reset && i_addr == 8'h20 |-> ##[1:2] o_chip_reset;
    endproperty
    a_soft_start: assert property (p_soft_start) else $error("soft reset not started");
    property p_soft_len;
        $rose(o_chip_reset) |-> ##[1:42] !o_chip_reset;
    endproperty
    a_soft_len: assert property (p_soft_len) else $error("soft reset too long");
    property p_hiz;
        o_chip_reset [*3] |-> o_driver_hiz && !o_irq_oe;
    endproperty
    a_hiz: assert property (p_hiz) else $error("outputs driven in reset");
endmodule
bind liu_irq_global_ctrl liu_irq_checker #(.CHIP_REVISION(CHIP_REVISION)) i_chk (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_irq_oe(o_irq_oe), .o_chip_reset(o_chip_reset), .o_driver_hiz(o_driver_hiz)
);
`default_nettype wire

// ---- tb/liu_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module liu_host_model (
    input wire logic i_sys_clk,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid,
    output logic [7:0] o_addr,
    output logic [7:0] o_wr_data,
    output logic o_wr_en,
    output logic o_rd_en
);
    initial begin
        o_addr = 8'h00;
        o_wr_data = 8'h00;
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        o_addr <= a;
        o_wr_data <= d;
        o_wr_en <= 1'b1;
        @(posedge i_sys_clk);
        o_wr_en <= 1'b0;
        o_wr_data <= ~d;
    endtask
    // Register reads; answer taken one edge after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        o_addr <= a;
        o_rd_en <= 1'b1;
        @(posedge i_sys_clk);
        o_rd_en <= 1'b0;
        @(posedge i_sys_clk);
        d = i_rd_valid ? i_rd_data : 8'hXX;
    endtask
endmodule
`default_nettype wire

// ---- tb/quad_liu_interrupt_and_global_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module quad_liu_interrupt_and_global_control_tb;
    import liu_irq_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [7:0] i_addr, i_wr_data, o_rd_data;
    logic i_wr_en, i_rd_en, o_rd_valid, o_irq_out, o_irq_oe, o_chip_reset, o_driver_hiz, std_sel;
    logic [3:0] mon_sel;
    logic [3:0][LIVE_EVENTS-1:0] line_st = '0;
    logic [3:0][PULSE_EVENTS-1:0] ev = '0;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    // Pull-up when the pin is released
    wire logic pin = o_irq_oe ? o_irq_out : 1'b1;
    always #12.5 i_sys_clk = ~i_sys_clk;
    liu_irq_global_ctrl i_dut (
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_line_state(line_st),
        .i_remote_loop_state(4'h0), .i_event_pulse(ev), .o_rd_data(o_rd_data),
        .o_rd_valid(o_rd_valid), .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe),
        .o_chip_reset(o_chip_reset), .o_driver_hiz(o_driver_hiz),
        .o_line_standard_select(std_sel), .o_monitor_select(mon_sel)
    );
    liu_host_model i_host (
        .i_sys_clk(i_sys_clk), .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid),
        .o_addr(i_addr), .o_wr_data(i_wr_data), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en)
    );
    function automatic logic [7:0] la(input int c, input logic [5:0] o);
        return {c[1:0], o};
    endfunction
    task automatic results();
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected=%h seen=%h", nm, exp, seen);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] v;
        i_host.rd(a, v);
        chk(nm, v, exp);
    endtask
    task automatic pin_chk(input logic exp);
        @(negedge i_sys_clk);
        chk("irq_pin", {7'h0, pin}, {7'h0, exp});
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    task automatic pulse(input int c, input int b);
        @(posedge i_sys_clk);
        ev <= 32'(1) << (c * 8 + b);
        @(posedge i_sys_clk);
        ev <= '0;
    endtask
    task automatic wait_rst(input logic lvl, input int lim, output int n);
        n = 0;
        while (o_chip_reset !== lvl && n < lim) begin
            @(posedge i_sys_clk);
            n++;
        end
    endtask
    task automatic t_defaults();
        logic [7:0] a[11] = '{8'h00, 8'h40, 8'h60, 8'h80, 8'h20, 8'hA0, 8'hC0, 8'hE0,
            8'hD1, 8'hD2, 8'hD3};
        logic [7:0] x[11] = '{CHIP_REVISION_DEFAULT, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
        int n;
        chk("hiz", {7'h0, o_driver_hiz}, 8'h01);
        wait_rst(1'b0, 100, n);
        chk("rst_end", {7'h0, o_chip_reset}, 8'h00);
        i_host.wr(8'h00, 8'hC3);
        for (int i = 0; i < 11; i++) rdchk(a[i], x[i], "default");
        pin_chk(1'b1);
        $display("t_defaults done");
    endtask
    task automatic t_pulses();
        i_host.wr(8'h40, 8'h01);
        i_host.wr(la(0, OFF_EVENT_ENABLE_B), 8'h00);
        i_host.wr(la(2, OFF_EVENT_ENABLE_B), 8'h00);
        for (int b = 0; b < 8; b++) begin
            pulse(0, b);
            wt(2);
            pin_chk(1'b0);
            rdchk(8'h80, 8'h01, "summary");
            rdchk(la(0, OFF_EVENT_LATCH_B), 8'(1 << b), "latch_b");
            rdchk(la(0, OFF_EVENT_LATCH_B), 8'h00, "latch_b clr");
            rdchk(8'h80, 8'h00, "summary clr");
            pin_chk(1'b1);
        end
        pulse(0, 1);
        pulse(2, 1);
        wt(2);
        rdchk(la(0, OFF_EVENT_LATCH_B), 8'h02, "latch_b ch0");
        rdchk(8'h80, 8'h10, "summary ch2");
        pin_chk(1'b0);
        rdchk(la(2, OFF_EVENT_LATCH_B), 8'h02, "latch_b ch2");
        pin_chk(1'b1);
        pulse(3, 0);
        wt(2);
        rdchk(8'h80, 8'h00, "summary masked");
        pin_chk(1'b1);
        rdchk(la(3, OFF_EVENT_LATCH_B), 8'h01, "latch masked");
        $display("t_pulses done");
    endtask
    task automatic t_live();
        i_host.wr(la(1, OFF_EVENT_ENABLE_A), 8'h00);
        for (int b = 0; b < 7; b++) begin
            for (int e = 0; e < 2; e++) begin
                i_host.wr(la(1, OFF_EDGE_SELECT), e ? 8'h7F : 8'h00);
                @(posedge i_sys_clk);
                line_st <= 28'(1) << (7 + b);
                wt(2);
                rdchk(la(1, OFF_LINE_CONDITION_A), 8'(1 << b), "line_cond");
                rdchk(la(1, OFF_EVENT_LATCH_A), 8'(1 << b), "latch_a rise");
                @(posedge i_sys_clk);
                line_st <= '0;
                wt(2);
                rdchk(8'h80, e ? 8'h04 : 8'h00, "summary fall");
                rdchk(la(1, OFF_EVENT_LATCH_A), e ? 8'(1 << b) : 8'h00, "latch_a fall");
            end
        end
        $display("t_live done");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 3; m++) begin
            i_host.wr(8'h40, 8'(m));
            pulse(0, 4);
            wt(2);
            pin_chk(m == 2);
            i_host.wr(8'h40, 8'(m + 4));
            wt(2);
            pin_chk(m != 2);
            rdchk(la(0, OFF_EVENT_LATCH_B), 8'h10, "latch_b");
        end
        $display("t_modes done");
    endtask
    task automatic t_bcast();
        i_host.wr(8'h40, 8'h11);
        i_host.wr(8'h60, 8'hA0);
        wt(1);
        chk("std_sel", {7'h0, std_sel}, 8'h01);
        chk("mon_sel", {4'h0, mon_sel}, 8'h0A);
        i_host.wr(la(1, OFF_EDGE_SELECT), 8'h11);
        for (int c = 0; c < 4; c++) rdchk(la(c, OFF_EDGE_SELECT), c == 1 ? 8'h11 : 8'h00, "edge");
        i_host.wr(8'h40, 8'h19);
        i_host.wr(la(2, OFF_EDGE_SELECT), 8'h22);
        for (int c = 0; c < 4; c++) rdchk(la(c, OFF_EDGE_SELECT), 8'h22, "edge bcast");
        $display("t_bcast done");
    endtask
    task automatic t_soft();
        int n;
        i_host.wr(8'h20, 8'h00);
        wait_rst(1'b1, 3, n);
        chk("soft_rst", {7'h0, o_chip_reset}, 8'h01);
        chk("hiz", {7'h0, o_driver_hiz}, 8'h01);
        wait_rst(1'b0, 45, n);
        chk("rst_len", 8'(n <= 42), 8'h01);
        rdchk(8'h40, 8'h04, "cfg_a");
        rdchk(la(2, OFF_EDGE_SELECT), 8'h00, "edge");
        rdchk(la(0, OFF_EVENT_ENABLE_B), 8'hFF, "enable_b");
        $display("t_soft done");
    endtask
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        t_defaults();
        t_pulses();
        t_live();
        t_modes();
        t_bcast();
        t_soft();
        results();
    end
endmodule
`default_nettype wire
